//--- link_controller_pin_glue.v
// Purpose: Control and status pin glue of a serial bus link controller
// Assumes: All pin inputs synchronous to core_clk; AHB-Lite register slave
// Notes:   Zero wait state slave; read data registered into the data phase
`timescale 1ns/1ns
`include "link_glue_defs.vh"

module link_controller_pin_glue #(
   parameter REQ_BITS = 12
) (
   input  wire        core_clk,
   input  wire        rstn,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   output wire        irq_pin_out,
   output wire        irq_pin_oe,
   output wire        irq_level,
   input  wire        isolation_strap_in,
   output reg         status_out_one,
   output wire        status_out_one_oe,
   output reg         status_out_zero,
   output reg         phy_request_out,
   input  wire [1:0]  host_type_select,
   input  wire [1:0]  host_bus_controls,
   input  wire        host_bus_clk,
   input  wire        host_system_clock,
   output reg         host_ready,
   input  wire        phy_sclk,
   output reg         internal_half_clock
);

   reg  [31:0]                io_control_q;
   reg  [31:0]                diagnostic_select_q;
   reg  [`IRQ_BITS-1:0]       irq_status_q;
   reg  [`IRQ_BITS-1:0]       irq_enable_q;
   reg                        strap_taken_q;
   reg                        strap_value_q;
   reg                        wr_pend_q;
   reg  [11:0]                wr_addr_q;
   reg  [REQ_BITS-1:0]        req_shift_q;
   reg  [4:0]                 req_count_q;
   reg                        req_done_q;
   reg                        sclk_prev_q;
   reg                        half_en_q;
   reg                        bus_clk_prev_q;
   reg                        sys_clk_prev_q;
   reg  [3:0]                 lps_count_q;
   reg                        lps_q;
   reg                        access_prev_q;
   reg                        map_over_q;
   reg  [`FIFO_SIZE_W*6-1:0]  fifo_size_q;
   reg  [31:0]                rd_data_d;
   reg                        access_d;
   reg                        status_out_zero_mux;
   reg                        status_out_one_mux;
   reg  [`IRQ_BITS-1:0]       irq_event;
   reg  [`FIFO_SIZE_W:0]      fifo_base [0:5];
   reg  [`FIFO_SIZE_W:0]      fifo_total;
   integer                    i;

   wire        addr_phase = hsel & hready & htrans[1];
   wire        rd_take    = addr_phase & ~hwrite;
   wire        wr_take    = addr_phase & hwrite;
   wire        irq_pending = |(irq_status_q & irq_enable_q);
   wire        req_busy   = (req_count_q != 5'h00);
   wire        access_start = access_d & ~access_prev_q;
   wire        access_end   = ~access_d & access_prev_q;
   wire        irq_pol    = io_control_q[`IOC_IRQ_POL_BIT];
   wire        link_on    = io_control_q[`IOC_LINK_ON_BIT];
   wire [3:0]  sel0       = diagnostic_select_q[`DIAGNOSTIC_SELECT_SEL0_LSB+3:`DIAGNOSTIC_SELECT_SEL0_LSB];
   wire [3:0]  sel1       = diagnostic_select_q[`DIAGNOSTIC_SELECT_SEL1_LSB+3:`DIAGNOSTIC_SELECT_SEL1_LSB];
   wire        wr_size_hit = wr_pend_q && ({wr_addr_q[11:5], 5'h00} == `OFS_FIFO_SIZE_BASE)
                             && (wr_addr_q[4:2] < 3'h6);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq_level = irq_pending;

   assign irq_pin_out = irq_pol;
   assign irq_pin_oe  = irq_pending;

   assign status_out_one_oe = strap_taken_q;

   // Address phase captured so the write lands with its data phase
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= wr_take;
         if (wr_take) begin
            wr_addr_q <= haddr;
         end
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         io_control_q <= `IOC_RESET_VAL;
         diagnostic_select_q       <= `DIAGNOSTIC_SELECT_RESET_VAL;
         irq_enable_q <= {`IRQ_BITS{1'b0}};
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            `OFS_IO_CONTROL: begin
               io_control_q <= {30'h00000000, hwdata[1:0]};
            end
            `OFS_IRQ_ENABLE: begin
               irq_enable_q <= hwdata[`IRQ_BITS-1:0];
            end
            `OFS_DIAGNOSTIC_SELECT_SELECT: begin
               diagnostic_select_q <= {24'h000000, hwdata[7:0]};
            end
            default: begin
               io_control_q <= io_control_q;
            end
         endcase
      end
   end

   // Six sizes in four quadlet units
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fifo_size_q <= {6{`FIFO_SIZE_RESET}};
      end else if (wr_size_hit) begin
         for (i = 0; i < 6; i = i + 1) begin
            if (wr_addr_q[4:2] == i[2:0]) begin
               fifo_size_q[i*`FIFO_SIZE_W +: `FIFO_SIZE_W] <= hwdata[`FIFO_SIZE_W-1:0];
            end
         end
      end
   end

   // Order: video tx/rx, async tx/rx, iso tx/rx
   always @* begin
      fifo_total = {(`FIFO_SIZE_W+1){1'b0}};
      for (i = 0; i < 6; i = i + 1) begin
         fifo_base[i] = fifo_total;
         fifo_total = fifo_total + {1'b0, fifo_size_q[i*`FIFO_SIZE_W +: `FIFO_SIZE_W]};
      end
   end

   // Overflow is flagged, not refused, so software sees its own mistake
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         map_over_q <= 1'b0;
      end else begin
         map_over_q <= (fifo_total > `FIFO_CAP_HEXLETS);
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap_taken_q <= 1'b0;
         strap_value_q <= 1'b1;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         strap_value_q <= isolation_strap_in;
      end
   end
   wire isolation_in_use = ~strap_value_q;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_prev_q         <= 1'b0;
         internal_half_clock <= 1'b0;
         half_en_q           <= 1'b0;
      end else begin
         sclk_prev_q <= phy_sclk;
         half_en_q   <= 1'b0;
         if (phy_sclk & ~sclk_prev_q) begin
            internal_half_clock <= ~internal_half_clock;
            half_en_q           <= ~internal_half_clock;
         end
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_shift_q     <= {REQ_BITS{1'b0}};
         req_count_q     <= 5'h00;
         phy_request_out <= 1'b0;
         req_done_q      <= 1'b0;
      end else begin
         req_done_q <= 1'b0;
         if (wr_pend_q && wr_addr_q == `OFS_PHY_REQUEST && !req_busy) begin
            req_shift_q <= hwdata[REQ_BITS-1:0];
            req_count_q <= REQ_BITS[4:0];
         end else if (req_busy && half_en_q) begin
            phy_request_out <= req_shift_q[REQ_BITS-1];
            req_shift_q     <= {req_shift_q[REQ_BITS-2:0], 1'b0};
            req_count_q     <= req_count_q - 5'h01;
            req_done_q      <= (req_count_q == 5'h01);
         end else if (half_en_q) begin
            // Last bit stands a full bit time before the line idles
            phy_request_out <= 1'b0;
         end
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_clk_prev_q <= 1'b0;
         sys_clk_prev_q <= 1'b0;
         lps_count_q    <= 4'h0;
         lps_q          <= 1'b0;
      end else begin
         bus_clk_prev_q <= host_bus_clk;
         sys_clk_prev_q <= host_system_clock;
         if (!link_on) begin
            lps_count_q <= 4'h0;
            lps_q       <= 1'b0;
         end else if (host_type_select[1] ? (host_system_clock & ~sys_clk_prev_q)
                                          : (host_bus_clk & ~bus_clk_prev_q)) begin
            lps_count_q <= lps_count_q + 4'h1;
            if (lps_count_q == `LPS_HALF_COUNT) begin
               lps_q <= ~lps_q;
            end
         end
      end
   end

   always @* begin
      access_d = 1'b0;
      case (host_type_select)
         `HOST_TYPE_STROBES: begin
            access_d = ~host_bus_controls[0] | ~host_bus_controls[1];
         end
         `HOST_TYPE_DS_RW: begin
            access_d = ~host_bus_controls[0];
         end
         `HOST_TYPE_EN_WR: begin
            access_d = host_bus_controls[0];
         end
         default: begin
            access_d = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         access_prev_q <= 1'b0;
         host_ready    <= 1'b0;
      end else begin
         access_prev_q <= access_d;
         if (access_start) begin
            host_ready <= 1'b1;
         end else if (access_end) begin
            host_ready <= 1'b0;
         end
      end
   end

   always @* begin
      irq_event = {`IRQ_BITS{1'b0}};
      irq_event[`IRQ_REQ_DONE_BIT] = req_done_q;
      irq_event[`IRQ_HOST_ACC_BIT] = access_start;
      irq_event[`IRQ_MAP_OVER_BIT] = map_over_q;
   end

   // A new event beats a clear in the same cycle
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_status_q <= {`IRQ_BITS{1'b0}};
      end else if (wr_pend_q && wr_addr_q == `OFS_IRQ_CLEAR) begin
         irq_status_q <= (irq_status_q & ~hwdata[`IRQ_BITS-1:0]) | irq_event;
      end else begin
         irq_status_q <= irq_status_q | irq_event;
      end
   end

   always @* begin
      status_out_zero_mux = 1'b0;
      status_out_one_mux = 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         case (i == 0 ? sel0 : sel1)
            `MUX_LPS:       status_out_one_mux = lps_q;
            `MUX_IRQ:       status_out_one_mux = irq_pending;
            `MUX_REQ_BUSY:  status_out_one_mux = req_busy;
            `MUX_HALF_CLK:  status_out_one_mux = internal_half_clock;
            `MUX_READY:     status_out_one_mux = host_ready;
            `MUX_ISO_STRAP: status_out_one_mux = strap_value_q;
            `MUX_HOST_ACC:  status_out_one_mux = access_prev_q;
            default:        status_out_one_mux = 1'b0;
         endcase
         if (i == 0) begin
            status_out_zero_mux = status_out_one_mux;
         end
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_out_zero <= 1'b0;
         status_out_one  <= 1'b0;
      end else begin
         status_out_zero <= (sel0 == `MUX_LPS) ? lps_q : status_out_zero_mux;
         status_out_one  <= status_out_one_mux;
      end
   end

   always @* begin
      rd_data_d = 32'h00000000;
      case (haddr)
         `OFS_IO_CONTROL:  rd_data_d = io_control_q;
         `OFS_IRQ_STATUS:  rd_data_d[`IRQ_BITS-1:0] = irq_status_q;
         `OFS_IRQ_ENABLE:  rd_data_d[`IRQ_BITS-1:0] = irq_enable_q;
         `OFS_PIN_STATUS:  rd_data_d = {24'h000000, host_type_select, host_ready, req_busy,
                                        lps_q, isolation_in_use, strap_value_q,
                                        strap_taken_q};
         `OFS_DIAGNOSTIC_SELECT_SELECT: rd_data_d = diagnostic_select_q;
         `OFS_FIFO_TOTAL:  rd_data_d[`FIFO_SIZE_W:0] = fifo_total;
         default: begin
            if ({haddr[11:5], 5'h00} == `OFS_FIFO_SIZE_BASE && haddr[4:2] < 3'h6) begin
               rd_data_d[`FIFO_SIZE_W-1:0] = fifo_size_q[haddr[4:2]*`FIFO_SIZE_W +: `FIFO_SIZE_W];
            end else if ({haddr[11:5], 5'h00} == `OFS_FIFO_BASE_BASE && haddr[4:2] < 3'h6) begin
               rd_data_d[`FIFO_SIZE_W:0] = fifo_base[haddr[4:2]];
            end
         end
      endcase
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h00000000;
      end else if (rd_take) begin
         hrdata <= rd_data_d;
      end
   end

endmodule

//--- link_controller_pin_glue_sva.sv
// Purpose: Port checker for the link controller pin glue block
// Assumes: One clock core_clk, asynchronous active low rstn
// Notes:   Host access decode mirrors the type table of the block
`timescale 1ns/1ns
module pin_glue_sva (
   input wire       core_clk,
   input wire       rstn,
   input wire       irq_level,
   input wire       irq_pin_oe,
   input wire       status_out_one_oe,
   input wire       host_ready,
   input wire [1:0] host_type_select,
   input wire [1:0] host_bus_controls,
   input wire       phy_sclk,
   input wire       internal_half_clock,
   input wire       phy_request_out
);
   wire acc = (host_type_select == 2'b00) ? ~&host_bus_controls :
              (host_type_select == 2'b01) ? ~host_bus_controls[0] :
              (host_type_select == 2'b10) ? host_bus_controls[0] : 1'b0;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_irq_pin_release: assert property (irq_pin_oe == irq_level)
      else $error("irq pin drive differs from pending level");
   a_ready_on_start: assert property ($rose(acc) |=> host_ready)
      else $error("ready missing after access start");
   a_ready_held: assert property (acc && host_ready |=> host_ready)
      else $error("ready dropped during access");
   a_ready_on_end: assert property ($fell(acc) |=> !host_ready)
      else $error("ready still high after access end");
   a_host_type_none: assert property (host_type_select == 2'b11 && !host_ready |=> !host_ready)
      else $error("ready raised with no host type");
   a_half_clock_step: assert property ($rose(phy_sclk) |-> ##[1:2] $changed(internal_half_clock))
      else $error("half clock did not follow phy clock edge");
   a_strap_pin_drive: assert property ($past(rstn) |-> status_out_one_oe)
      else $error("status one pin not driven after reset");
   a_request_bit_time: assert property ($rose(phy_request_out) |->
      $past(internal_half_clock) || $past(internal_half_clock, 2))
      else $error("request bit changed off the half clock");
   c_host_access: cover property ($rose(host_ready));
   c_irq_driven: cover property ($rose(irq_pin_oe));
   c_request_bit: cover property ($rose(phy_request_out));
endmodule

bind link_controller_pin_glue pin_glue_sva u_pin_glue_sva (
   .core_clk(core_clk), .rstn(rstn), .irq_level(irq_level), .irq_pin_oe(irq_pin_oe),
   .status_out_one_oe(status_out_one_oe), .host_ready(host_ready),
   .host_type_select(host_type_select), .host_bus_controls(host_bus_controls),
   .phy_sclk(phy_sclk), .internal_half_clock(internal_half_clock),
   .phy_request_out(phy_request_out));

//--- link_controller_pin_glue_tb.sv
// Purpose: Self-checking bench for the link controller pin glue block
// Assumes: Zero wait register slave; xorshift stimulus from a fixed seed
// Notes:   Request width cut to 8 bits to keep serial transfers short
`timescale 1ns/1ns
`include "link_glue_defs.vh"
module link_controller_pin_glue_tb;
   localparam RB = 8;
   logic          core_clk, rstn, hsel, hwrite, host_bus_clk, host_system_clock, strap_level;
   logic [11:0]   haddr;
   logic [1:0]    htrans, host_type_select, host_bus_controls;
   logic [31:0]   hwdata, rd, seed, v;
   wire           hreadyout, hresp, irq_pin_out, irq_pin_oe, irq_level, host_ready;
   wire           status_out_one, status_out_one_oe, status_out_zero, phy_request_out;
   wire           phy_sclk, internal_half_clock, isolation_strap_in;
   wire [31:0]    hrdata;
   wire [RB-1:0]  rx_bits;
   int            failures, checked, n;

   link_controller_pin_glue #(.REQ_BITS(RB)) u_link_controller_pin_glue (
      .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_pin_out, .irq_pin_oe,
      .irq_level, .isolation_strap_in, .status_out_one, .status_out_one_oe,
      .status_out_zero, .phy_request_out, .host_type_select, .host_bus_controls,
      .host_bus_clk, .host_system_clock, .host_ready, .phy_sclk, .internal_half_clock);
   phy_side_model #(.REQ_BITS(RB)) u_phy_side_model (
      .strap_level, .status_out_one, .status_out_one_oe, .internal_half_clock,
      .phy_request_out, .phy_sclk, .isolation_strap_in, .rx_bits);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function [31:0] xs(input [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
   endfunction
   function logic acc_of(input logic [1:0] t, input logic [1:0] c);
      case (t)
         2'b00: acc_of = ~&c;
         2'b01: acc_of = ~c[0];
         2'b10: acc_of = c[0];
         default: acc_of = 1'b0;
      endcase
   endfunction
   function [31:0] strap_exp(input logic s);
      strap_exp = {29'h0, ~s, s, 1'b0};
   endfunction

   task give_verdict;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step_rdy;
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (hreadyout !== 1'b1) begin
         failures++;
         give_verdict;
      end
   endtask
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      step_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      step_rdy;
      rd = hrdata;
   endtask
   task do_reset(input logic s);
      rstn <= 1'b0;
      strap_level <= s;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
   endtask
   // Used clock rises every 4 cycles, the other toggles each cycle
   task lps_run(input logic sys);
      int i, e, last, tg;
      logic p;
      e = 0;
      last = 0;
      tg = 0;
      // Let a select written just before reach the pin
      repeat (2) @(posedge core_clk);
      p = status_out_zero;
      for (i = 0; i < 240; i++) begin
         @(posedge core_clk);
         if (status_out_zero !== p) begin
            if (tg > 0) chk(e - last, 16);
            tg++;
            last = e;
            p = status_out_zero;
         end
         if (i[1:0] == 2'b01) e++;
         host_bus_clk <= sys ? i[0] : i[1];
         host_system_clock <= sys ? i[1] : i[0];
      end
      chk(tg > 2, 1);
   endtask

   initial begin
      failures = 0;
      checked = 0;
      seed = 32'hf21f;
      {rstn, hsel, hwrite, host_bus_clk, host_system_clock, strap_level} = 6'h0;
      {haddr, htrans, hwdata} = 0;
      host_type_select = 2'b00;
      host_bus_controls = 2'b11;
      do_reset(1'b0);
      bus(0, `OFS_IO_CONTROL, 0); chk(rd, `IOC_RESET_VAL);
      chk(hresp, 1'b0);
      bus(0, `OFS_DIAGNOSTIC_SELECT_SELECT, 0); chk(rd, `DIAGNOSTIC_SELECT_RESET_VAL);
      bus(1, 12'h100, 32'hffffffff); bus(0, 12'h100, 0); chk(rd, 0);
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         bus(0, `OFS_PIN_STATUS, 0); chk(rd & 32'h6, strap_exp(s[0]));
         strap_level <= ~s[0];
         bus(0, `OFS_PIN_STATUS, 0); chk(rd & 32'h6, strap_exp(s[0]));
         bus(1, `OFS_DIAGNOSTIC_SELECT_SELECT, 32'h55);
         repeat (3) @(posedge core_clk);
         chk({status_out_one, status_out_zero}, {2{s[0]}});
      end
      repeat (4) begin
         seed = xs(seed);
         bus(1, `OFS_DIAGNOSTIC_SELECT_SELECT, seed); bus(0, `OFS_DIAGNOSTIC_SELECT_SELECT, 0); chk(rd, seed & 32'hff);
      end
      host_type_select <= 2'b01;
      bus(1, `OFS_IRQ_CLEAR, 32'h7);
      bus(1, `OFS_IRQ_ENABLE, 32'h2);
      host_bus_controls <= 2'b10;
      repeat (3) @(posedge core_clk);
      host_bus_controls <= 2'b11;
      repeat (2) @(posedge core_clk);
      chk({irq_pin_oe, irq_pin_out}, 2'b10);
      bus(1, `OFS_IO_CONTROL, 32'h3); @(posedge core_clk); chk(irq_pin_out, 1);
      bus(1, `OFS_IRQ_ENABLE, 0); @(posedge core_clk); chk(irq_pin_oe, 0);
      bus(1, `OFS_IRQ_ENABLE, 32'h2); bus(0, `OFS_IRQ_STATUS, 0); chk(rd, 32'h2);
      bus(1, `OFS_IRQ_CLEAR, 32'h2); @(posedge core_clk); chk(irq_pin_oe, 0);
      bus(1, `OFS_IRQ_ENABLE, 0);
      for (int t = 0; t < 4; t++) begin
         host_type_select <= t[1:0];
         repeat (40) begin
            @(posedge core_clk);
            seed = xs(seed);
            v = acc_of(host_type_select, host_bus_controls);
            host_bus_controls <= seed[1:0];
            #1 chk(host_ready, v);
         end
      end
      host_type_select <= 2'b00;
      host_bus_controls <= 2'b11;
      bus(1, `OFS_DIAGNOSTIC_SELECT_SELECT, 0);
      lps_run(1'b0);
      host_type_select <= 2'b10;
      host_bus_controls <= 2'b00;
      lps_run(1'b1);
      // Third size: one random, one largest so the map overflows
      for (int f = 0; f < 2; f++) begin
         seed = xs(seed);
         v = f ? 32'h3ff : (seed & 32'h3ff);
         bus(1, `OFS_FIFO_SIZE_BASE + 12'h008, v | 32'hfffffc00);
         bus(0, `OFS_FIFO_SIZE_BASE + 12'h008, 0); chk(rd, v);
         bus(0, `OFS_FIFO_BASE_BASE + 12'h00c, 0); chk(rd, 32'h0a0 + v);
         bus(0, `OFS_FIFO_TOTAL, 0); chk(rd, 32'h190 + v);
         bus(0, `OFS_IRQ_STATUS, 0);
         chk(rd & 32'h4, (32'h190 + v > 32'h200) ? 32'h4 : 32'h0);
      end
      bus(1, `OFS_FIFO_SIZE_BASE + 12'h008, 32'h50);
      bus(1, `OFS_IRQ_CLEAR, 32'h7);
      bus(1, `OFS_IRQ_ENABLE, 32'h1);
      seed = xs(seed);
      bus(1, `OFS_PHY_REQUEST, seed);
      bus(1, `OFS_PHY_REQUEST, ~seed);
      n = 0;
      while (irq_level !== 1'b1 && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      // Last bit is taken at the next fall of the half clock
      while (internal_half_clock !== 1'b0 && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      @(posedge core_clk);
      if (n >= 600) failures++;
      chk(rx_bits, seed[RB-1:0]);
      give_verdict;
   end
endmodule

//--- link_glue_defs.vh
// Purpose: Constants for the link controller pin glue block
// Assumes: Included by link_controller_pin_glue.v and by the testbench
// Notes:   Offsets are byte addresses on the register bus
`ifndef LINK_GLUE_DEFS_VH
`define LINK_GLUE_DEFS_VH

`define OFS_IO_CONTROL      12'h000
`define OFS_IRQ_STATUS      12'h004
`define OFS_IRQ_CLEAR       12'h008
`define OFS_IRQ_ENABLE      12'h00c
`define OFS_PIN_STATUS      12'h010
`define OFS_PHY_REQUEST     12'h014
`define OFS_DIAGNOSTIC_SELECT_SELECT     12'h030
`define OFS_FIFO_SIZE_BASE  12'h040
`define OFS_FIFO_BASE_BASE  12'h060
`define OFS_FIFO_TOTAL      12'h078

`define IOC_IRQ_POL_BIT     0
`define IOC_LINK_ON_BIT     1
`define IOC_RESET_VAL       32'h00000002

`define DIAGNOSTIC_SELECT_SEL0_LSB       0
`define DIAGNOSTIC_SELECT_SEL1_LSB       4
`define DIAGNOSTIC_SELECT_RESET_VAL      32'h00000000

`define IRQ_REQ_DONE_BIT    0
`define IRQ_HOST_ACC_BIT    1
`define IRQ_MAP_OVER_BIT    2
`define IRQ_BITS            3

`define FIFO_SIZE_W         10
`define FIFO_SIZE_RESET     10'h050
`define FIFO_CAP_HEXLETS    11'h200

`define LPS_HALF_COUNT      4'hf

`define HOST_TYPE_STROBES   2'b00
`define HOST_TYPE_DS_RW     2'b01
`define HOST_TYPE_EN_WR     2'b10
`define HOST_TYPE_NONE      2'b11

`define MUX_LPS             4'h0
`define MUX_IRQ             4'h1
`define MUX_REQ_BUSY        4'h2
`define MUX_HALF_CLK        4'h3
`define MUX_READY           4'h4
`define MUX_ISO_STRAP       4'h5
`define MUX_HOST_ACC        4'h6

`endif

//--- phy_side_model.sv
// Purpose: Physical layer side of the pin glue: clock, strap and request capture
// Assumes: Strap resistor only decides the pin while the block releases it
// Notes:   Request bits are taken mid-bit, at the fall of the half clock
`timescale 1ns/1ns
module phy_side_model #(
   parameter REQ_BITS = 12
) (
   input  wire                 strap_level,
   input  wire                 status_out_one,
   input  wire                 status_out_one_oe,
   input  wire                 internal_half_clock,
   input  wire                 phy_request_out,
   output logic                phy_sclk,
   output wire                 isolation_strap_in,
   output logic [REQ_BITS-1:0] rx_bits
);
   // Block drive wins over the strap resistor once it owns the pin
   assign isolation_strap_in = status_out_one_oe ? status_out_one : strap_level;
   // Offset by 1 ns so no edge meets a core_clk rising edge
   initial begin
      phy_sclk = 1'b0;
      #1;
      forever #10 phy_sclk = ~phy_sclk;
   end
   always @(negedge internal_half_clock) begin
      rx_bits <= {rx_bits[REQ_BITS-2:0], phy_request_out};
   end
endmodule
